// ==== design/ecc_ctrl.sv ====
/*
  ecc_ctrl: control of one capture/compare/PWM unit, its output
  steering for single, half and full bridge, auto-shutdown and dead
  band, plus the shared timer selection registers.
  Assumes timers, duty comparator and flag logic live outside; the
  compare match and raw PWM come from logic on the same clock.
*/
// Added by the designer: the placing of the registers and the strobed register port.
// Function
// [RQ1] mode 0000 holds unit off; 0001/0011 reserved
// [RQ2] mode 0010 toggles pin on each match
// [RQ3] capture on fall, rise, 4th or 16th rise
// [RQ4] 1000 sets, 1001 clears pin; flag set
// [RQ5] 1010 match only sets the flag
// [RQ6] 1011 sets flag and resets selected timer
// [RQ7] fifth unit trigger also sets converter enable
// [RQ8] control bits 5-4 are duty low bits
// [RQ9] non-PWM: A is capture/compare, others port
// [RQ10] half bridge: 0x single, 1x dead-band pair
// [RQ11] full bridge: 00 single, 10 half bridge
// [RQ12] forward and reverse full bridge pin drive
// [RQ13] mode bits 1/0 set A-C and B-D polarity
// [RQ14] timer choice code picks the time bases
// [RQ15] low select register holds units 1-3
// [RQ16] high select register holds units 4-5
// [RQ17] shutdown source field picks the trigger
// [RQ18] shutdown event sets status, forces safe pins
// [RQ19] restart enable clears status when event ends
// [RQ20] pair fields drive low, high or release
// [RQ21] synced comparator shutdown waits for timer 1
// [RQ22] dead band delays active-going edges
// [RQ23] flag requests are single-clock pulses
`timescale 1ns/1ns
module ecc_ctrl #(
  parameter int UNIT_NUM  = 1,
  parameter int BRIDGE    = ecc_pkg::BRIDGE_FULL
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic [ecc_pkg::ADDR_W-1:0]  addr,
  input  wire logic [ecc_pkg::DATA_W-1:0]  wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic      [ecc_pkg::DATA_W-1:0]  rdata,
  input  wire logic [7:0]                  duty_high_register,
  input  wire logic                        capture_pin,
  input  wire logic                        fault_input,
  input  wire logic                        comp1_raw_output,
  input  wire logic                        comp2_raw_output,
  input  wire logic                        comp1_sync_enable,
  input  wire logic                        comp2_sync_enable,
  input  wire logic                        timer1_tick,
  input  wire logic                        compare_match,
  input  wire logic                        pwm_raw,
  output logic                             unit_held,
  output logic [9:0]                       duty_value,
  output logic [2:0]                       cc_timer,
  output logic [2:0]                       pwm_timer,
  output logic                             capture_event,
  output logic                             unit_event_flag_set,
  output logic                             timer_reset,
  output logic                             converter_enable_set,
  output logic                             shutdown_flag_set,
  output logic                             shutdown_status,
  output logic                             output_a_o,
  output logic                             output_a_oe,
  output logic                             output_b_o,
  output logic                             output_b_oe,
  output logic                             output_c_o,
  output logic                             output_c_oe,
  output logic                             output_d_o,
  output logic                             output_d_oe
);
  import ecc_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [2:0] timer_num(input logic [1:0] code,
                                           input logic       pwm);
    if (code == TSEL_RSVD) begin
      timer_num = 3'h0;
    end else begin
      timer_num = {code, 1'b0} + {2'h0, pwm} + 3'h1;
    end
  endfunction : timer_num

  function automatic logic sd_select(input logic [2:0] src,
                                     input logic       flt_low,
                                     input logic       c1,
                                     input logic       c2);
    case (src)
      SRC_C1:   sd_select = c1;
      SRC_C2:   sd_select = c2;
      SRC_C12:  sd_select = c1 | c2;
      SRC_F:    sd_select = flt_low;
      SRC_FC1:  sd_select = flt_low | c1;
      SRC_FC2:  sd_select = flt_low | c2;
      SRC_FC12: sd_select = flt_low | c1 | c2;
      default:  sd_select = 1'b0;
    endcase
  endfunction : sd_select

  function automatic logic [1:0] safe_pin(input logic [1:0] field);
    // {enable, level}: 1x releases the pair
    safe_pin = {~field[1], field[0]};
  endfunction : safe_pin

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]    ctrl_q;
  logic [7:0]    tsl_q;
  logic [7:0]    tsh_q;
  logic [6:0]    sdc_q;
  logic [7:0]    rdb_q;
  logic          status_q;
  ecc_class_type class_q;
  logic          wr_ctrl;
  logic          wr_sd;
  logic [3:0]    mode;
  logic [1:0]    cfg_eff;
  logic          pol_ac;
  logic          pol_bd;
  logic [1:0]    tcode;

  assign wr_ctrl = wr && (addr == OFF_CONTROL);
  assign wr_sd   = wr && (addr == OFF_SHUTDN);
  assign mode    = ctrl_q[3:0];
  assign pol_ac  = mode[1]; // RQ13
  assign pol_bd  = mode[0]; // RQ13

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= RST_REG;
      tsl_q  <= RST_REG;
      tsh_q  <= RST_REG;
      sdc_q  <= RST_REG[6:0];
      rdb_q  <= RST_REG;
    end else if (ce && wr) begin
      if (addr == OFF_CONTROL) begin
        ctrl_q <= (BRIDGE == BRIDGE_NONE) ? (wdata & MASK_STD) : wdata;
      end else if (addr == OFF_TSEL_LO) begin
        tsl_q <= wdata & MASK_TSL; // RQ15
      end else if (addr == OFF_TSEL_HI) begin
        tsh_q <= wdata & MASK_TSH; // RQ16
      end else if (addr == OFF_SHUTDN) begin
        sdc_q <= wdata[6:0];
      end else if (addr == OFF_RESTART) begin
        rdb_q <= wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= RST_REG;
    end else if (ce) begin
      if (!rd) begin
        rdata <= RST_REG;
      end else if (addr == OFF_CONTROL) begin
        rdata <= ctrl_q;
      end else if (addr == OFF_TSEL_LO) begin
        rdata <= tsl_q;
      end else if (addr == OFF_TSEL_HI) begin
        rdata <= tsh_q;
      end else if (addr == OFF_SHUTDN) begin
        rdata <= {status_q, sdc_q};
      end else if (addr == OFF_RESTART) begin
        rdata <= rdb_q;
      end else begin
        rdata <= RST_REG;
      end
    end
  end

  // ****************************************************************
  // mode class and timer choice
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      class_q <= CLS_OFF;
    end else if (ce) begin
      case (mode)
        MODE_OFF:                 class_q <= CLS_OFF; // RQ1
        MODE_TOGGLE:              class_q <= CLS_COMPARE;
        MODE_CAP_F, MODE_CAP_R,
        MODE_CAP_R4, MODE_CAP_R16: class_q <= CLS_CAPTURE;
        MODE_CMP_SET, MODE_CMP_CLR,
        MODE_CMP_SW, MODE_SPECIAL: class_q <= CLS_COMPARE;
        default: begin
          if (mode[3:2] == MODE_PWM_TOP) begin
            class_q <= CLS_PWM;
          end else begin
            class_q <= CLS_OFF; // RQ1
          end
        end
      endcase
    end
  end

  always_comb begin
    case (UNIT_NUM)
      2:       tcode = tsl_q[TSL_U2_LSB +: 2]; // RQ15
      3:       tcode = tsl_q[TSL_U3_LSB +: 2]; // RQ15
      4:       tcode = tsh_q[TSH_U4_LSB +: 2]; // RQ16
      5:       tcode = tsh_q[TSH_U5_LSB +: 2]; // RQ16
      default: tcode = tsl_q[TSL_U1_LSB +: 2]; // RQ15
    endcase
    if (BRIDGE == BRIDGE_FULL) begin
      cfg_eff = ctrl_q[CTRL_CFG_LSB +: 2]; // RQ11
    end else if (BRIDGE == BRIDGE_HALF) begin
      cfg_eff = {ctrl_q[CTRL_CFG_LSB + 1], 1'b0}; // RQ10
    end else begin
      cfg_eff = CFG_SINGLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cc_timer   <= 3'h0;
      pwm_timer  <= 3'h0;
      duty_value <= 10'h000;
      unit_held  <= 1'b1;
    end else if (ce) begin
      cc_timer   <= timer_num(tcode, 1'b0); // RQ14
      pwm_timer  <= timer_num(tcode, 1'b1); // RQ14
      duty_value <= {duty_high_register,
                     ctrl_q[CTRL_DUTY_LSB +: 2]}; // RQ8
      unit_held  <= (class_q == CLS_OFF); // RQ1
    end
  end

  // ****************************************************************
  // two-flop pin synchronisers
  // ****************************************************************
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else if (ce) begin
      sync1_q <= {comp2_raw_output, comp1_raw_output,
                  ~fault_input, capture_pin};
      sync2_q <= sync1_q;
    end
  end

  // ****************************************************************
  // capture and compare
  // ****************************************************************
  logic       cap_prev_q;
  logic [3:0] pre_q;
  logic       match_prev_q;
  logic       cc_pin_q;
  logic       rise;
  logic       fall;
  logic       match_p;
  logic       cap_hit;
  logic       cmp_flag;

  assign rise    = sync2_q[0] & ~cap_prev_q;
  assign fall    = ~sync2_q[0] & cap_prev_q;
  assign match_p = compare_match & ~match_prev_q;
  assign cmp_flag = match_p && (class_q == CLS_COMPARE) && mode[3];

  always_comb begin
    cap_hit = 1'b0;
    if (class_q == CLS_CAPTURE) begin
      case (mode)
        MODE_CAP_F:   cap_hit = fall; // RQ3
        MODE_CAP_R:   cap_hit = rise; // RQ3
        MODE_CAP_R4:  cap_hit = rise && (pre_q == PRE4_LAST); // RQ3
        default:      cap_hit = rise && (pre_q == PRE16_LAST); // RQ3
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cap_prev_q   <= 1'b0;
      match_prev_q <= 1'b0;
      pre_q        <= 4'h0;
    end else if (ce) begin
      cap_prev_q   <= sync2_q[0];
      match_prev_q <= compare_match;
      if (wr_ctrl || class_q != CLS_CAPTURE) begin
        pre_q <= 4'h0; // RQ1
      end else if (rise) begin
        if (cap_hit) begin
          pre_q <= 4'h0;
        end else begin
          pre_q <= pre_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cc_pin_q <= 1'b0;
    end else if (ce) begin
      if (class_q == CLS_OFF) begin
        cc_pin_q <= 1'b0; // RQ1
      end else if (match_p && class_q == CLS_COMPARE) begin
        if (mode == MODE_TOGGLE) begin
          cc_pin_q <= ~cc_pin_q; // RQ2
        end else if (mode == MODE_CMP_SET) begin
          cc_pin_q <= 1'b1; // RQ4
        end else if (mode == MODE_CMP_CLR) begin
          cc_pin_q <= 1'b0; // RQ4
        end
      end
    end
  end

  // one-cycle requests to flag, timer, converter
  always_ff @(posedge clk) begin
    if (rst) begin
      capture_event        <= 1'b0;
      unit_event_flag_set  <= 1'b0;
      timer_reset          <= 1'b0;
      converter_enable_set <= 1'b0;
    end else if (ce) begin
      capture_event        <= cap_hit;
      unit_event_flag_set  <= cap_hit | cmp_flag; // RQ4 RQ5 RQ23
      timer_reset          <= cmp_flag && mode == MODE_SPECIAL; // RQ6
      converter_enable_set <= cmp_flag && mode == MODE_SPECIAL
                              && UNIT_NUM == 5; // RQ7
    end
  end

  // ****************************************************************
  // auto-shutdown
  // ****************************************************************
  logic c1_hold_q;
  logic c2_hold_q;
  logic c1_eff;
  logic c2_eff;
  logic sd_event;

  always_ff @(posedge clk) begin
    if (rst) begin
      c1_hold_q <= 1'b0;
      c2_hold_q <= 1'b0;
    end else if (ce && timer1_tick) begin
      c1_hold_q <= sync2_q[2]; // RQ21
      c2_hold_q <= sync2_q[3]; // RQ21
    end
  end

  assign c1_eff   = comp1_sync_enable ? c1_hold_q : sync2_q[2]; // RQ21
  assign c2_eff   = comp2_sync_enable ? c2_hold_q : sync2_q[3]; // RQ21
  assign sd_event = sd_select(sdc_q[SD_SRC_LSB +: 3], sync2_q[1],
                              c1_eff, c2_eff); // RQ17

  always_ff @(posedge clk) begin
    if (rst) begin
      status_q          <= 1'b0;
      shutdown_flag_set <= 1'b0;
    end else if (ce) begin
      shutdown_flag_set <= sd_event & ~status_q; // RQ23
      if (sd_event || (wr_sd && wdata[SD_STATUS_BIT])) begin
        status_q <= 1'b1; // RQ18
      end else if (class_q == CLS_OFF) begin
        status_q <= 1'b0;
      end else if (rdb_q[RS_EN_BIT]) begin
        status_q <= 1'b0; // RQ19
      end else if (wr_sd) begin
        status_q <= 1'b0; // RQ19
      end
    end
  end

  assign shutdown_status = status_q;

  // ****************************************************************
  // dead band
  // ****************************************************************
  logic       pwm_prev_q;
  logic [9:0] db_q;
  logic [9:0] db_d;
  logic       act_a_q;
  logic       act_b_q;

  always_comb begin
    if (pwm_raw != pwm_prev_q) begin
      db_d = 10'(rdb_q[6:0]) * 10'(INSN_CLKS); // RQ22
    end else if (db_q != 10'h000) begin
      db_d = db_q - 10'h001;
    end else begin
      db_d = 10'h000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_prev_q <= 1'b0;
      db_q       <= 10'h000;
      act_a_q    <= 1'b0;
      act_b_q    <= 1'b0;
    end else if (ce) begin
      pwm_prev_q <= pwm_raw;
      db_q       <= db_d;
      act_a_q    <= pwm_raw && (db_d == 10'h000); // RQ22
      act_b_q    <= !pwm_raw && (db_d == 10'h000); // RQ22
    end
  end

  // ****************************************************************
  // output steering: {d, c, b, a}
  // ****************************************************************
  logic [3:0] lvl;
  logic [3:0] en;
  logic [3:0] out_q;
  logic [3:0] oe_q;
  logic [1:0] ss_ac;
  logic [1:0] ss_bd;

  assign ss_ac = safe_pin(sdc_q[SD_AC_LSB +: 2]);
  assign ss_bd = safe_pin(sdc_q[SD_BD_LSB +: 2]);

  always_comb begin
    lvl = 4'h0;
    en  = 4'h0;
    if (class_q == CLS_PWM) begin
      case (cfg_eff)
        CFG_SINGLE: begin
          lvl = {3'h0, pwm_raw ^ pol_ac}; // RQ10 RQ11
          en  = 4'h1;
        end
        CFG_HALF: begin
          lvl = {2'h0, act_b_q ^ pol_bd, act_a_q ^ pol_ac}; // RQ10
          en  = 4'h3; // RQ11
        end
        CFG_FWD: begin
          lvl = {pwm_raw ^ pol_bd, pol_ac, pol_bd, ~pol_ac}; // RQ12
          en  = 4'hf;
        end
        default: begin
          lvl = {pol_bd, ~pol_ac, pwm_raw ^ pol_bd, pol_ac}; // RQ12
          en  = 4'hf;
        end
      endcase
      if (status_q) begin
        lvl = {ss_bd[0], ss_ac[0], ss_bd[0], ss_ac[0]}; // RQ20
        en  = en & {ss_bd[1], ss_ac[1], ss_bd[1], ss_ac[1]}; // RQ18
      end
    end else if (class_q == CLS_COMPARE) begin
      lvl = {3'h0, cc_pin_q}; // RQ9
      en  = 4'h1; // RQ9
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_q <= 4'h0;
      oe_q  <= 4'h0;
    end else if (ce) begin
      out_q <= lvl & en;
      oe_q  <= en;
    end
  end

  assign output_a_o  = out_q[0];
  assign output_b_o  = out_q[1];
  assign output_c_o  = out_q[2];
  assign output_d_o  = out_q[3];
  assign output_a_oe = oe_q[0];
  assign output_b_oe = oe_q[1];
  assign output_c_oe = oe_q[2];
  assign output_d_oe = oe_q[3];
endmodule : ecc_ctrl

// ==== include/ecc_pkg.sv ====
/*
  ecc_pkg: offsets, field positions, reset values, mode codes and
  timing constants of the capture/compare/PWM control block.
  Assumes an 8-bit register port and a 125 MHz system clock.
*/
package ecc_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int         ADDR_W      = 3;
  localparam int         DATA_W      = 8;
  localparam logic [2:0] OFF_CONTROL = 3'h0;
  localparam logic [2:0] OFF_TSEL_LO = 3'h1;
  localparam logic [2:0] OFF_TSEL_HI = 3'h2;
  localparam logic [2:0] OFF_SHUTDN  = 3'h3;
  localparam logic [2:0] OFF_RESTART = 3'h4;
  localparam logic [2:0] OFF_DUTY_HI = 3'h5;
  localparam logic [7:0] RST_REG     = 8'h00;
  localparam logic [7:0] MASK_STD    = 8'h3f;
  localparam logic [7:0] MASK_TSL    = 8'hdb;
  localparam logic [7:0] MASK_TSH    = 8'h0f;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_DUTY_LSB = 4;
  localparam int CTRL_CFG_LSB  = 6;
  localparam int SD_STATUS_BIT = 7;
  localparam int SD_SRC_LSB    = 4;
  localparam int SD_AC_LSB     = 2;
  localparam int SD_BD_LSB     = 0;
  localparam int RS_EN_BIT     = 7;
  localparam int TSL_U1_LSB    = 0;
  localparam int TSL_U2_LSB    = 3;
  localparam int TSL_U3_LSB    = 6;
  localparam int TSH_U4_LSB    = 0;
  localparam int TSH_U5_LSB    = 2;
  // ****************************************************************
  // mode, configuration and source codes
  // ****************************************************************
  localparam logic [3:0] MODE_OFF     = 4'h0;
  localparam logic [3:0] MODE_TOGGLE  = 4'h2;
  localparam logic [3:0] MODE_CAP_F   = 4'h4;
  localparam logic [3:0] MODE_CAP_R   = 4'h5;
  localparam logic [3:0] MODE_CAP_R4  = 4'h6;
  localparam logic [3:0] MODE_CAP_R16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SW  = 4'ha;
  localparam logic [3:0] MODE_SPECIAL = 4'hb;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  localparam logic [1:0] CFG_SINGLE   = 2'h0;
  localparam logic [1:0] CFG_FWD      = 2'h1;
  localparam logic [1:0] CFG_HALF     = 2'h2;
  localparam logic [1:0] CFG_REV      = 2'h3;
  localparam logic [1:0] TSEL_RSVD    = 2'h3;
  localparam logic [2:0] SRC_C1       = 3'h1;
  localparam logic [2:0] SRC_C2       = 3'h2;
  localparam logic [2:0] SRC_C12      = 3'h3;
  localparam logic [2:0] SRC_F        = 3'h4;
  localparam logic [2:0] SRC_FC1      = 3'h5;
  localparam logic [2:0] SRC_FC2      = 3'h6;
  localparam logic [2:0] SRC_FC12     = 3'h7;
  localparam int         BRIDGE_NONE  = 0;
  localparam int         BRIDGE_HALF  = 1;
  localparam int         BRIDGE_FULL  = 2;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int         CLK_NS     = 8;
  localparam int         INSN_NS    = 4 * CLK_NS;
  localparam int         INSN_CLKS  = (INSN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] PRE4_LAST  = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hf;
  typedef enum logic [1:0] {
    CLS_OFF, CLS_CAPTURE, CLS_COMPARE, CLS_PWM
  } ecc_class_type;
endpackage : ecc_pkg

// ==== verif/ecc_partner.sv ====
/*
  ecc_partner: fault, comparator and capture sources.
  Assumes the bench commands each source on cmd.
*/
`timescale 1ns/1ns
module ecc_partner (
  input  wire logic [3:0] cmd,
  output logic            capture_pin,
  output logic            fault_input,
  output logic            comp1_raw_output,
  output logic            comp2_raw_output
);
  // sources move off the clock grid, like real async pins
  assign #3 capture_pin      = cmd[0];
  assign #3 fault_input      = !cmd[1];
  assign #3 comp1_raw_output = cmd[2];
  assign #3 comp2_raw_output = cmd[3];
endmodule : ecc_partner

// ==== verif/ecc_chk.sv ====
/*
  ecc_chk: port assertions for ecc_ctrl.
  Assumes one clock domain and ce held high.
*/
`timescale 1ns/1ns
module ecc_chk
  import ecc_pkg::*;
#(
  parameter int UNIT_NUM = 1
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       unit_held,
  input wire logic [2:0] cc_timer,
  input wire logic [2:0] pwm_timer,
  input wire logic       capture_event,
  input wire logic       unit_event_flag_set,
  input wire logic       timer_reset,
  input wire logic       converter_enable_set,
  input wire logic       shutdown_flag_set,
  input wire logic       shutdown_status,
  input wire logic       output_a_o,
  input wire logic       output_a_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_off_write;
    ce && wr && addr == OFF_CONTROL && wdata[3:0] == MODE_OFF;
  endsequence
  sequence s_status_rise;
    shutdown_status && !$past(shutdown_status);
  endsequence
  a_held_off: assert property (s_off_write |-> ##[1:3] unit_held)
    else $error("unit not held after off write");
  a_read_idle: assert property ($past(ce) && !$past(rd) |-> !rdata)
    else $error("read data outside read slot");
  a_tsl_holes: assert property (
    ce && rd && addr == OFF_TSEL_LO |=> !rdata[5] && !rdata[2])
    else $error("unused select bits read nonzero");
  a_tsh_upper: assert property (
    ce && rd && addr == OFF_TSEL_HI |=> rdata[7:4] == 4'h0)
    else $error("upper select bits read nonzero");
  a_flag_once: assert property (
    ce && unit_event_flag_set |=> !unit_event_flag_set)
    else $error("event flag request longer than one cycle");
  a_shut_once: assert property (shutdown_flag_set |-> s_status_rise)
    else $error("shutdown request without fresh status");
  a_timer_pair: assert property (
    (pwm_timer == cc_timer + 3'h1 && cc_timer[0]) ||
    (cc_timer == 3'h0 && pwm_timer == 3'h0))
    else $error("timer pair inconsistent");
  a_conv_five: assert property (
    converter_enable_set == (timer_reset && UNIT_NUM == 5))
    else $error("converter start outside special trigger");
  a_cap_flag: assert property (
    capture_event |-> ##[0:1] unit_event_flag_set)
    else $error("capture without event flag");
  a_tri_zero: assert property (output_a_oe || !output_a_o)
    else $error("released pin shows a level");
endmodule : ecc_chk

// ==== verif/enhanced_ccp_control_test.sv ====
/*
  enhanced_ccp_control_test: self-checking bench for ecc_ctrl.
  Assumes unit 1 on a full bridge, ce held high.
*/
`timescale 1ns/1ns
module enhanced_ccp_control_test;
  import ecc_pkg::*;
  logic clk, rst, ce, wr, rd, compare_match, pwm_raw, timer1_tick;
  logic comp1_sync_enable, comp2_sync_enable, unit_held, capture_event;
  logic unit_event_flag_set, timer_reset, converter_enable_set;
  logic shutdown_flag_set, shutdown_status, capture_pin, fault_input;
  logic comp1_raw_output, comp2_raw_output;
  logic output_a_o, output_a_oe, output_b_o, output_b_oe;
  logic output_c_o, output_c_oe, output_d_o, output_d_oe;
  logic [2:0] addr, cc_timer, pwm_timer;
  logic [7:0] wdata, rdata, duty_high_register, v;
  logic [9:0] duty_value;
  logic [3:0] cmd;
  logic [3:0] cm [6] = '{4'h9, 4'h8, 4'ha, 4'hb, 4'h2, 4'h2};
  logic [5:0] cp = 6'b101110;
  int cx [4] = '{16, 16, 4, 1};
  int n_errors, checks, seed, i, k, la, lb, nf, ntr, nce, nsd, ncap, nexp;
  wire [7:0] pv = {output_a_o, output_a_oe, output_b_o, output_b_oe,
                   output_c_o, output_c_oe, output_d_o, output_d_oe};
  initial clk = 1'b0;
  always #4 clk = ~clk;
  ecc_ctrl dut (.*);
  ecc_partner u_far (.*);
  always @(posedge clk) if (!rst) begin
    nf += unit_event_flag_set;
    ntr += timer_reset;
    nce += converter_enable_set;
    nsd += shutdown_flag_set;
    ncap += capture_event;
  end
  // ********
  // bus and compare helpers
  // ********
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic cmp(input logic [15:0] g, e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 cmp(rdata, e);
  endtask : rd_chk
  function automatic logic [7:0] msk(input int a);
    case (a)
      1: return 8'hdb;
      2: return 8'h0f;
      5, 6, 7: return 8'h00;
      default: return 8'hff;
    endcase
  endfunction : msk
  // pin pairs {o, oe} for a, b, c, d in pwm class
  function automatic logic [7:0] pexp(input logic [1:0] c, m,
                                      input logic r);
    logic [3:0] o, e;
    case (c)
      2'b00: {o, e} = {r ^ m[1], 3'b000, 4'b1000};
      2'b10: {o, e} = {r ^ m[1], !r ^ m[0], 6'b001100};
      2'b01: {o, e} = {!m[1], m[0], m[1], r ^ m[0], 4'hf};
      default: {o, e} = {m[1], r ^ m[0], !m[1], m[0], 4'hf};
    endcase
    return {o[3], e[3], o[2], e[2], o[1], e[1], o[0], e[0]};
  endfunction : pexp
  task automatic tally_and_finish;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // ********
  // scenarios
  // ********
  initial begin
    seed = 87;
    {ce, rst, wr, rd, compare_match, pwm_raw, timer1_tick} = 7'h60;
    {comp1_sync_enable, comp2_sync_enable} = 2'b00;
    {addr, wdata, duty_high_register, cmd} = '0;
    tick(3);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) rd_chk(i[2:0], 8'h00);
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      v[7] = 1'b0;
      wr_reg(i[2:0], v);
      rd_chk(i[2:0], v & msk(i));
    end
    for (i = 0; i < 5; i++) wr_reg(i[2:0], 8'h00);
    for (i = 0; i < 4; i++) begin
      wr_reg(OFF_TSEL_LO, {6'h00, i[1:0]});
      tick(2);
      cmp(cc_timer, i < 3 ? 2 * i + 1 : 0);
      cmp(pwm_timer, i < 3 ? 2 * i + 2 : 0);
    end
    for (i = 0; i < 6; i++) begin
      wr_reg(OFF_CONTROL, {4'h0, cm[i]});
      tick(2);
      compare_match <= 1'b1;
      tick(1);
      compare_match <= 1'b0;
      tick(3);
      #1 cmp(output_a_o, cp[i]);
      cmp(pv[5:0], 6'h00);
    end
    cmp(nf, 4);
    cmp(ntr, 1);
    cmp(nce, 0);
    for (i = 0; i < 4; i++) begin
      wr_reg(OFF_CONTROL, 8'h04 + i[7:0]);
      tick(2);
      k = ncap;
      repeat (16) begin
        cmd[0] <= 1'b1;
        tick(3);
        cmd[0] <= 1'b0;
        tick(3);
      end
      tick(6);
      cmp(ncap - k, cx[i]);
    end
    v = $random(seed);
    wr_reg(OFF_CONTROL, 8'h3c);
    duty_high_register <= v;
    tick(3);
    cmp(duty_value, {v, 2'b11});
    for (i = 0; i < 32; i++) begin
      v = {i[3:2], 4'h3, i[1:0]};
      wr_reg(OFF_CONTROL, v);
      pwm_raw <= i[4];
      tick(6);
      #1 cmp(pv, pexp(v[7:6], v[1:0], i[4]));
    end
    wr_reg(OFF_RESTART, 8'h03);
    wr_reg(OFF_CONTROL, 8'h8c);
    pwm_raw <= 1'b0;
    tick(20);
    pwm_raw <= 1'b1;
    la = 0;
    lb = 0;
    for (k = 1; k < 40; k++) begin
      @(posedge clk);
      #1;
      if (lb == 0 && !output_b_o) lb = k;
      if (la == 0 && output_a_o) la = k;
    end
    cmp(la - lb, 12);
    wr_reg(OFF_RESTART, 8'h00);
    wr_reg(OFF_CONTROL, 8'h4c);
    nexp = nsd;
    for (i = 0; i < 8; i++) for (k = 1; k < 4; k++) begin
      wr_reg(OFF_SHUTDN, {1'b0, i[2:0], 4'b0110});
      cmd[k] <= 1'b1;
      tick(8);
      v[0] = i[(k + 1) % 3];
      nexp += v[0];
      #1 cmp(shutdown_status, v[0]);
      if (v[0]) cmp(pv, 8'hcc);
      @(posedge clk) cmd[k] <= 1'b0;
      tick(8);
      #1 cmp(shutdown_status, v[0]);
    end
    wr_reg(OFF_RESTART, 8'h80);
    wr_reg(OFF_SHUTDN, 8'h40);
    cmd[1] <= 1'b1;
    tick(8);
    #1 cmp(shutdown_status, 1'b1);
    @(posedge clk) cmd[1] <= 1'b0;
    tick(8);
    #1 cmp(shutdown_status, 1'b0);
    cmp(pv, pexp(2'b01, 2'b00, pwm_raw));
    wr_reg(OFF_SHUTDN, 8'h10);
    comp1_sync_enable <= 1'b1;
    cmd[2] <= 1'b1;
    tick(8);
    #1 cmp(shutdown_status, 1'b0);
    @(posedge clk) timer1_tick <= 1'b1;
    @(posedge clk) timer1_tick <= 1'b0;
    tick(4);
    #1 cmp(shutdown_status, 1'b1);
    cmp(nsd, nexp + 2);
    wr_reg(OFF_CONTROL, 8'h01);
    tick(3);
    #1 cmp(unit_held, 1'b1);
    tally_and_finish();
  end
endmodule : enhanced_ccp_control_test
bind ecc_ctrl ecc_chk #(.UNIT_NUM(UNIT_NUM)) u_chk (.*);
